// ### verilog/paravirt_mmio_pkg.sv
package paravirt_mmio_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int LANES = 4;

  // Control register offsets, all aligned 32-bit words
  localparam logic [11:0] OFF_DRV_FEAT = 12'h020;
  localparam logic [11:0] OFF_DRV_FEAT_SEL = 12'h024;
  localparam logic [11:0] OFF_PAGE_SIZE = 12'h028;
  localparam logic [11:0] OFF_QUEUE_SEL = 12'h030;
  localparam logic [11:0] OFF_QUEUE_LIMIT = 12'h034;
  localparam logic [11:0] OFF_QUEUE_COUNT = 12'h038;
  localparam logic [11:0] OFF_USED_ALIGN = 12'h03C;
  localparam logic [11:0] OFF_QUEUE_PAGE = 12'h040;
  localparam logic [11:0] OFF_DOORBELL = 12'h050;
  localparam logic [11:0] OFF_IRQ_FLAGS = 12'h060;
  localparam logic [11:0] OFF_IRQ_CLEAR = 12'h064;
  localparam logic [11:0] OFF_PROGRESS = 12'h070;
  localparam logic [11:0] OFF_CFG_BASE = 12'h100;

  // Interrupt cause bit positions
  localparam int IRQ_W = 2;
  localparam int IRQ_USED_BIT = 0;
  localparam int IRQ_CONFIG_BIT = 1;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [63:0] RST_ADDR = 64'h0000_0000_0000_0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Documented defaults for the module parameters
  localparam int DEF_NUM_QUEUES = 8;
  localparam int DEF_QUEUE_MAX = 256;
  localparam int DEF_FEAT_WORDS = 2;
  localparam int DEF_CFG_BYTES = 16;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [31:0] count;
    logic [31:0] align;
    logic [31:0] page;
    logic [63:0] base_addr;
  } queue_cfg_s;

endpackage : paravirt_mmio_pkg

// ### verilog/queue_slot.sv
`timescale 1ns/10ps
`default_nettype none
module queue_slot
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic sel_i,
  input wire logic count_we_i,
  input wire logic align_we_i,
  input wire logic page_we_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] page_size_i,
  output paravirt_mmio_pkg::queue_cfg_s cfg_o
);

  paravirt_mmio_pkg::queue_cfg_s st;
  paravirt_mmio_pkg::queue_cfg_s next_st;

  always_comb
  begin
    next_st = st;
    if (sel_i && count_we_i)
      next_st.count = wdata_i;
    if (sel_i && align_we_i)
      next_st.align = wdata_i;
    if (sel_i && page_we_i)
      next_st.page = wdata_i;
    if (clear_i)
    begin
      next_st.count = paravirt_mmio_pkg::RST_WORD;
      next_st.align = paravirt_mmio_pkg::RST_WORD;
      next_st.page = paravirt_mmio_pkg::RST_WORD;
    end
    // Tracks page size changes too, one cycle behind
    next_st.base_addr = 64'(next_st.page) * 64'(page_size_i);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st.count <= paravirt_mmio_pkg::RST_WORD;
      st.align <= paravirt_mmio_pkg::RST_WORD;
      st.page <= paravirt_mmio_pkg::RST_WORD;
      st.base_addr <= paravirt_mmio_pkg::RST_ADDR;
    end
    else if (ce_i)
      st <= next_st;
  end

  assign cfg_o = st;

endmodule : queue_slot
`default_nettype wire

// ### verilog/irq_cause_latch.sv
`timescale 1ns/10ps
`default_nettype none
module irq_cause_latch
#(
  parameter int W = 2
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clear_all_i,
  input wire logic ack_we_i,
  input wire logic [W-1:0] ack_mask_i,
  input wire logic [W-1:0] set_i,
  output logic [W-1:0] pend_o,
  output logic irq_o
);

  typedef struct packed {
    logic [W-1:0] pend;
    logic irq;
  } irq_state_s;

  irq_state_s st;
  irq_state_s next_st;

  always_comb
  begin
    next_st = st;
    if (ack_we_i)
      next_st.pend = st.pend & ~ack_mask_i;
    if (clear_all_i)
      next_st.pend = '0;
    // New cause in the clearing cycle must not be lost
    next_st.pend = next_st.pend | set_i;
    next_st.irq = |next_st.pend;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st.pend <= '0;
      st.irq <= 1'b0;
    end
    else if (ce_i)
      st <= next_st;
  end

  assign pend_o = st.pend;
  assign irq_o = st.irq;

endmodule : irq_cause_latch
`default_nettype wire

// ### verilog/paravirt_mmio_control_regs.sv
`timescale 1ns/10ps
`default_nettype none
module paravirt_mmio_control_regs
#(
  parameter int NUM_QUEUES = paravirt_mmio_pkg::DEF_NUM_QUEUES,
  parameter int QUEUE_MAX = paravirt_mmio_pkg::DEF_QUEUE_MAX,
  parameter int FEAT_WORDS = paravirt_mmio_pkg::DEF_FEAT_WORDS,
  parameter int CFG_BYTES = paravirt_mmio_pkg::DEF_CFG_BYTES
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire paravirt_mmio_pkg::reg_req_s reg_req_i,
  input wire logic used_ring_update_i,
  input wire logic config_change_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_ack_o,
  output logic irq_o,
  output logic kick_valid_o,
  output logic [31:0] kick_queue_o,
  output logic device_reset_o,
  output logic [31:0] page_size_o,
  output logic [31:0] progress_o,
  output logic [FEAT_WORDS*32-1:0] driver_features_o,
  output logic [CFG_BYTES*8-1:0] cfg_space_o,
  output paravirt_mmio_pkg::queue_cfg_s [NUM_QUEUES-1:0] queue_cfg_o
);

  localparam int QIDX_W = (NUM_QUEUES > 1) ? $clog2(NUM_QUEUES) : 1;
  localparam int FIDX_W = (FEAT_WORDS > 1) ? $clog2(FEAT_WORDS) : 1;
  localparam int CIDX_W = 12;
  localparam logic [31:0] QUEUE_LIMIT = 32'(QUEUE_MAX);

  typedef struct packed {
    logic [31:0] feat_sel;
    logic [FEAT_WORDS-1:0][31:0] feat;
    logic [31:0] page_size;
    logic [31:0] qsel;
    logic [31:0] progress;
    logic [CFG_BYTES-1:0][7:0] cfg;
    logic [31:0] rdata;
    logic ack;
    logic kick_v;
    logic [31:0] kick_q;
    logic dev_rst;
  } top_state_s;

  top_state_s st;
  top_state_s next_st;

  logic wr;
  logic rd;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic sel_ok;
  logic [QIDX_W-1:0] qidx;
  logic soft_rst;
  logic count_we;
  logic align_we;
  logic page_we;
  logic ack_we;
  logic [paravirt_mmio_pkg::IRQ_W-1:0] irq_set;
  logic [paravirt_mmio_pkg::IRQ_W-1:0] irq_pend;
  logic in_cfg;
  logic [CIDX_W-1:0] cfg_off;
  paravirt_mmio_pkg::queue_cfg_s [NUM_QUEUES-1:0] slot_cfg;
  paravirt_mmio_pkg::queue_cfg_s cur_q;

  // Register data is carried lane for lane, so guest byte order is kept
  assign wr = reg_req_i.wr;
  assign rd = reg_req_i.rd;
  assign addr = reg_req_i.addr;
  assign wdata = reg_req_i.wdata;

  // Out-of-range select acts as an absent queue
  assign sel_ok = st.qsel < 32'(NUM_QUEUES);
  assign qidx = st.qsel[QIDX_W-1:0];
  always_comb
  begin
    cur_q = '0;
    if (sel_ok)
      cur_q = slot_cfg[qidx];
  end

  assign soft_rst = wr && (addr == paravirt_mmio_pkg::OFF_PROGRESS)
    && (wdata == paravirt_mmio_pkg::RST_WORD);
  assign count_we = wr && (addr == paravirt_mmio_pkg::OFF_QUEUE_COUNT);
  assign align_we = wr && (addr == paravirt_mmio_pkg::OFF_USED_ALIGN);
  assign page_we = wr && (addr == paravirt_mmio_pkg::OFF_QUEUE_PAGE);
  assign ack_we = wr && (addr == paravirt_mmio_pkg::OFF_IRQ_CLEAR);

  always_comb
  begin
    irq_set = '0;
    irq_set[paravirt_mmio_pkg::IRQ_USED_BIT] = used_ring_update_i;
    irq_set[paravirt_mmio_pkg::IRQ_CONFIG_BIT] = config_change_i;
  end

  assign in_cfg = addr >= paravirt_mmio_pkg::OFF_CFG_BASE;
  // Wraps below the base, but only used when in_cfg holds
  assign cfg_off = addr - paravirt_mmio_pkg::OFF_CFG_BASE;

  // One slot per queue, only the selected one takes queue word writes; soft reset clears every slot
  genvar g;
  generate
    for (g = 0; g < NUM_QUEUES; g++)
    begin : g_slot
      queue_slot u_slot
      (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .clear_i(soft_rst),
        .sel_i(sel_ok && (qidx == QIDX_W'(g))),
        .count_we_i(count_we),
        .align_we_i(align_we),
        .page_we_i(page_we),
        .wdata_i(wdata),
        .page_size_i(st.page_size),
        .cfg_o(slot_cfg[g])
      );
    end
  endgenerate

  // Set wins over acknowledge and soft reset
  irq_cause_latch #(.W(paravirt_mmio_pkg::IRQ_W)) u_irq
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clear_all_i(soft_rst),
    .ack_we_i(ack_we),
    .ack_mask_i(wdata[paravirt_mmio_pkg::IRQ_W-1:0]),
    .set_i(irq_set),
    .pend_o(irq_pend),
    .irq_o(irq_o)
  );

  always_comb
  begin
    logic [CIDX_W-1:0] bidx;
    next_st = st;
    bidx = '0;
    next_st.ack = wr || rd;
    next_st.kick_v = 1'b0;
    next_st.dev_rst = 1'b0;

    if (wr)
    begin
      unique case (addr)
        paravirt_mmio_pkg::OFF_DRV_FEAT_SEL:
          next_st.feat_sel = wdata;
        paravirt_mmio_pkg::OFF_DRV_FEAT:
        begin
          // Words past the implemented groups are dropped
          if (st.feat_sel < 32'(FEAT_WORDS))
            next_st.feat[st.feat_sel[FIDX_W-1:0]] = wdata;
        end
        paravirt_mmio_pkg::OFF_PAGE_SIZE:
          next_st.page_size = wdata;
        paravirt_mmio_pkg::OFF_QUEUE_SEL:
          next_st.qsel = wdata;
        paravirt_mmio_pkg::OFF_DOORBELL:
        begin
          next_st.kick_v = 1'b1;
          next_st.kick_q = wdata;
        end
        paravirt_mmio_pkg::OFF_PROGRESS:
        begin
          if (wdata == paravirt_mmio_pkg::RST_WORD)
          begin
            next_st.progress = paravirt_mmio_pkg::RST_WORD;
            next_st.dev_rst = 1'b1;
          end
          else
            next_st.progress = st.progress | wdata;
        end
        paravirt_mmio_pkg::OFF_QUEUE_COUNT,
        paravirt_mmio_pkg::OFF_USED_ALIGN,
        paravirt_mmio_pkg::OFF_QUEUE_PAGE,
        paravirt_mmio_pkg::OFF_IRQ_CLEAR:
        begin
          // Taken by the queue slots and the cause latch
        end
        paravirt_mmio_pkg::OFF_QUEUE_LIMIT,
        paravirt_mmio_pkg::OFF_IRQ_FLAGS:
        begin
          // Read-only words, a write is acked and dropped
        end
        default:
        begin
          // Byte lanes map to consecutive configuration bytes
          if (in_cfg)
          begin
            for (int i = 0; i < paravirt_mmio_pkg::LANES; i++)
            begin
              bidx = cfg_off + CIDX_W'(i);
              if (reg_req_i.be[i] && (bidx < CIDX_W'(CFG_BYTES)))
                next_st.cfg[bidx] = wdata[8*i +: 8];
            end
          end
        end
      endcase
    end

    if (rd)
    begin
      // Write-only and unmapped offsets read as zero
      next_st.rdata = paravirt_mmio_pkg::RST_WORD;
      unique case (addr)
        paravirt_mmio_pkg::OFF_QUEUE_LIMIT:
          next_st.rdata = sel_ok ? QUEUE_LIMIT : paravirt_mmio_pkg::RST_WORD;
        paravirt_mmio_pkg::OFF_QUEUE_PAGE:
          next_st.rdata = cur_q.page;
        paravirt_mmio_pkg::OFF_IRQ_FLAGS:
          next_st.rdata = 32'(irq_pend);
        paravirt_mmio_pkg::OFF_PROGRESS:
          next_st.rdata = st.progress;
        // Write-only words give zero rather than stale data
        paravirt_mmio_pkg::OFF_DRV_FEAT,
        paravirt_mmio_pkg::OFF_DRV_FEAT_SEL,
        paravirt_mmio_pkg::OFF_PAGE_SIZE,
        paravirt_mmio_pkg::OFF_QUEUE_SEL,
        paravirt_mmio_pkg::OFF_QUEUE_COUNT,
        paravirt_mmio_pkg::OFF_USED_ALIGN,
        paravirt_mmio_pkg::OFF_DOORBELL,
        paravirt_mmio_pkg::OFF_IRQ_CLEAR:
          next_st.rdata = paravirt_mmio_pkg::RST_WORD;
        default:
        begin
          if (in_cfg)
          begin
            for (int i = 0; i < paravirt_mmio_pkg::LANES; i++)
            begin
              bidx = cfg_off + CIDX_W'(i);
              if (bidx < CIDX_W'(CFG_BYTES))
                next_st.rdata[8*i +: 8] = st.cfg[bidx];
            end
          end
        end
      endcase
    end
  end

  // Low clock enable freezes the ack and reset pulses as well
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st.feat_sel <= paravirt_mmio_pkg::RST_WORD;
      st.feat <= '0;
      st.page_size <= paravirt_mmio_pkg::RST_WORD;
      st.qsel <= paravirt_mmio_pkg::RST_WORD;
      st.progress <= paravirt_mmio_pkg::RST_WORD;
      st.cfg <= '0;
      st.rdata <= paravirt_mmio_pkg::RST_WORD;
      st.ack <= 1'b0;
      st.kick_v <= 1'b0;
      st.kick_q <= paravirt_mmio_pkg::RST_WORD;
      st.dev_rst <= 1'b0;
    end
    else if (ce_i)
      st <= next_st;
  end

  assign reg_rdata_o = st.rdata;
  assign reg_ack_o = st.ack;
  assign kick_valid_o = st.kick_v;
  assign kick_queue_o = st.kick_q;
  assign device_reset_o = st.dev_rst;
  assign page_size_o = st.page_size;
  assign progress_o = st.progress;
  assign driver_features_o = st.feat;
  assign cfg_space_o = st.cfg;
  assign queue_cfg_o = slot_cfg;

endmodule : paravirt_mmio_control_regs
`default_nettype wire

// ### testbench/paravirt_mmio_control_regs_props.sv
`timescale 1ns/10ps
`default_nettype none
module paravirt_mmio_control_regs_props
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire paravirt_mmio_pkg::reg_req_s reg_req_i,
  input wire logic used_ring_update_i,
  input wire logic config_change_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic irq_o,
  input wire logic kick_valid_o,
  input wire logic [31:0] kick_queue_o,
  input wire logic device_reset_o,
  input wire logic [31:0] page_size_o,
  input wire logic [31:0] progress_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic wr;
  logic rd;
  logic ev;
  logic [11:0] ad;
  logic [31:0] wd;
  assign wr = ce_i && reg_req_i.wr;
  assign rd = ce_i && reg_req_i.rd;
  assign ev = used_ring_update_i || config_change_i;
  assign ad = reg_req_i.addr;
  assign wd = reg_req_i.wdata;
  page_size_a: assert property (wr && ad == 12'h028 |=> page_size_o == $past(wd))
    else $error("page size not stored");
  kick_pulse_a: assert property (wr && ad == 12'h050 |=> kick_valid_o && kick_queue_o == $past(wd))
    else $error("doorbell not announced");
  kick_single_a: assert property (ce_i && !(wr && ad == 12'h050) |=> !kick_valid_o)
    else $error("doorbell pulse without write");
  used_flag_a: assert property (ce_i && used_ring_update_i |=> irq_o)
    else $error("used ring cause lost");
  config_flag_a: assert property (ce_i && config_change_i |=> irq_o)
    else $error("config cause lost");
  cause_read_a: assert property (rd && ad == 12'h060 && !ev
    |=> reg_rdata_o[31:2] == 30'h0 && irq_o == |reg_rdata_o[1:0])
    else $error("cause read and interrupt disagree");
  cause_clear_a: assert property (wr && ad == 12'h064 && wd[1:0] == 2'h3 && !ev |=> !irq_o)
    else $error("causes not cleared");
  progress_set_a: assert property (wr && ad == 12'h070 && wd != 32'h0
    |=> progress_o == ($past(progress_o) | $past(wd)))
    else $error("progress flags not accumulated");
  soft_reset_a: assert property (wr && ad == 12'h070 && wd == 32'h0 && !ev
    |=> device_reset_o && progress_o == 32'h0 && !irq_o)
    else $error("soft reset not taken");
  cover property (kick_valid_o);
  cover property (device_reset_o);
  cover property ($rose(irq_o));
endmodule : paravirt_mmio_control_regs_props
bind paravirt_mmio_control_regs paravirt_mmio_control_regs_props i_props (.clk_i, .rst_i, .ce_i,
  .reg_req_i, .used_ring_update_i, .config_change_i, .reg_rdata_o, .irq_o, .kick_valid_o,
  .kick_queue_o, .device_reset_o, .page_size_o, .progress_o);
`default_nettype wire

// ### testbench/paravirt_mmio_control_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module paravirt_mmio_control_regs_tb;
  localparam int NQ = 8;
  localparam int QM = 256;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic used_ring_update_i = 1'b0;
  logic config_change_i = 1'b0;
  paravirt_mmio_pkg::reg_req_s reg_req_i = '0;
  logic [31:0] reg_rdata_o;
  logic reg_ack_o;
  logic irq_o;
  logic kick_valid_o;
  logic [31:0] kick_queue_o;
  logic device_reset_o;
  logic [31:0] page_size_o;
  logic [31:0] progress_o;
  logic [63:0] driver_features_o;
  logic [127:0] cfg_space_o;
  paravirt_mmio_pkg::queue_cfg_s [NQ-1:0] queue_cfg_o;
  logic [32:0] expq[$];
  logic [32:0] note;
  logic [31:0] seed = 32'hE6F3;
  logic [31:0] a;
  logic [31:0] b;
  logic [63:0] feats;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;

  paravirt_mmio_control_regs #(.NUM_QUEUES(NQ), .QUEUE_MAX(QM), .FEAT_WORDS(2), .CFG_BYTES(16))
  i_paravirt_mmio_control_regs (.clk_i, .rst_i, .ce_i, .reg_req_i, .used_ring_update_i,
    .config_change_i, .reg_rdata_o, .reg_ack_o, .irq_o, .kick_valid_o, .kick_queue_o,
    .device_reset_o, .page_size_o, .progress_o, .driver_features_o, .cfg_space_o, .queue_cfg_o);

  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // Request held across exactly one rising edge; caller issues the next access or idles at once
  task automatic acc(input logic w, input logic [11:0] ad, input logic [31:0] d,
    input logic [3:0] be, input logic [32:0] e);
    reg_req_i = '{wr: w, rd: !w, addr: ad, be: be, wdata: d};
    expq.push_back(e);
    @(negedge clk_i);
  endtask : acc

  task automatic wr_reg(input logic [11:0] ad, input logic [31:0] d);
    acc(1'b1, ad, d, 4'hF, 33'h0);
  endtask : wr_reg

  task automatic rd_reg(input logic [11:0] ad, input logic [31:0] e);
    acc(1'b0, ad, 32'h0, 4'hF, {1'b1, e});
  endtask : rd_reg

  task automatic idle();
    reg_req_i = '0;
    @(negedge clk_i);
  endtask : idle

  // Never call twice in a row: the low edge lands in the same step as the next raise
  task automatic ev(input logic u, input logic c);
    reg_req_i = '0;
    used_ring_update_i = u;
    config_change_i = c;
    @(negedge clk_i);
    used_ring_update_i = 1'b0;
    config_change_i = 1'b0;
  endtask : ev

  always @(negedge clk_i)
  begin
    if (reg_ack_o === 1'b1)
    begin
      note = expq.pop_front();
      if (note[32])
        cmp("read data", note[31:0], reg_rdata_o);
    end
  end

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    a = rnd();
    b = rnd();
    wr_reg(12'h024, 32'h0);
    wr_reg(12'h020, a);
    wr_reg(12'h024, 32'h1);
    wr_reg(12'h020, b);
    wr_reg(12'h024, 32'h2);
    wr_reg(12'h020, rnd());
    idle();
    feats = {b, a};
    cmp("features", feats, driver_features_o);
    $display("feature words done");
    wr_reg(12'h028, 32'h0000_1000);
    for (int q = 0; q <= NQ; q++)
    begin
      a = rnd() & 32'h0000_FFFF | 32'h0000_0001;
      wr_reg(12'h030, q);
      rd_reg(12'h040, 32'h0);
      rd_reg(12'h034, q < NQ ? QM : 0);
      wr_reg(12'h038, q < NQ ? q + 16 : 0);
      wr_reg(12'h03C, 32'h0000_0040 << (q % 4));
      wr_reg(12'h040, a);
      rd_reg(12'h040, q < NQ ? a : 0);
      idle();
      if (q < NQ)
      begin
        cmp("count", q + 16, queue_cfg_o[q].count);
        cmp("align", 32'h0000_0040 << (q % 4), queue_cfg_o[q].align);
        cmp("base", a * 64'h1000, queue_cfg_o[q].base_addr);
      end
    end
    cmp("page size", 32'h0000_1000, page_size_o);
    cmp("queue 0 kept", 16, queue_cfg_o[0].count);
    $display("queue setup done");
    a = rnd() & 32'h0000_0007;
    wr_reg(12'h050, a);
    cmp("kick", {1'b1, a}, {kick_valid_o, kick_queue_o});
    idle();
    cmp("kick end", 0, kick_valid_o);
    $display("doorbell done");
    ev(1'b1, 1'b0);
    cmp("irq set", 1, irq_o);
    rd_reg(12'h060, 32'h1);
    ev(1'b0, 1'b1);
    rd_reg(12'h060, 32'h3);
    wr_reg(12'h064, 32'h1);
    rd_reg(12'h060, 32'h2);
    idle();
    cmp("irq held", 1, irq_o);
    wr_reg(12'h064, 32'h2);
    idle();
    cmp("irq low", 0, irq_o);
    $display("interrupt causes done");
    a = rnd() | 32'h0000_0001;
    b = rnd() | 32'h0000_0002;
    wr_reg(12'h070, a);
    wr_reg(12'h070, b);
    rd_reg(12'h070, a | b);
    ev(1'b1, 1'b0);
    wr_reg(12'h070, 32'h0);
    cmp("reset pulse", 1, device_reset_o);
    cmp("progress", 0, progress_o);
    cmp("irq cleared", 0, irq_o);
    cmp("queue page", 0, queue_cfg_o[3].page);
    cmp("queue count", 0, queue_cfg_o[0].count);
    idle();
    cmp("reset end", 0, device_reset_o);
    cmp("features kept", feats, driver_features_o);
    cmp("page size kept", 32'h0000_1000, page_size_o);
    $display("status and soft reset done");
    a = rnd();
    acc(1'b1, 12'h104, a, 4'h5, 33'h0);
    rd_reg(12'h104, a & 32'h00FF_00FF);
    rd_reg(12'h102, {8'h00, a[7:0], 16'h0000});
    wr_reg(12'h030, 32'h3);
    rd_reg(12'h040, 32'h0);
    idle();
    cmp("config byte", a[23:16], cfg_space_o[55:48]);
    $display("config space done");
    ce_i = 1'b0;
    reg_req_i = '{wr: 1'b1, rd: 1'b0, addr: 12'h028, be: 4'hF, wdata: 32'h0000_2000};
    @(negedge clk_i);
    reg_req_i = '0;
    ce_i = 1'b1;
    cmp("frozen page size", 32'h0000_1000, page_size_o);
    $display("clock enable done");
    repeat (2) @(negedge clk_i);
    cmp("answers missing", 0, expq.size());
    report_and_stop();
  end
endmodule : paravirt_mmio_control_regs_tb
`default_nettype wire
